//--- include/pcc_pkg.sv
// Constants, modes and carrier structs for the port charging and power control block.
// Assumes one core clock and a synchronous active-high reset.
// Behaviour
// - Four-bit per-port charging enable field.
// - Charging downstream mode needs VBUS, configured, power.
// - Unconnected upstream with automatic mode off gives dedicated charging mode.
// - Divider modes only unconnected with automatic mode.
// - Divider mode presents fixed level on data lines.
// - Unconnected and enabled asserts port power enable.
// - Automatic mode off uses dedicated charging.
// - Start highest divider mode, stay without pull-up.
// - Divider pull-up: power off, vendor or dedicated.
// - Vendor pull-up: power off, then dedicated mode.
// - Dedicated pull-up or voltage detect returns divider.
// - Register settings map to charging mode table.
// - Strapped automatic mode alternates divider-2 and dedicated.
// - Settings from registers if configured, else straps.
// - Charging enabled forces per-port power switching.
// - Power switch disable and ganged bits select switching.
// - Power enable outputs follow polarity bit.
// - Upstream speed limits downstream superspeed and high speed.
// - Strap pins latched two cycles after reset release.
package pcc_pkg;

    localparam int PCC_PORTS = 4;
    localparam int PCC_OFF_TIME_NS = 100000;
    localparam int PCC_CLK_PERIOD_NS = 4;
    localparam int PCC_OFF_CYCLES = (PCC_OFF_TIME_NS + PCC_CLK_PERIOD_NS - 1) / PCC_CLK_PERIOD_NS;
    localparam int PCC_CNT_W = 16;

    localparam int PCC_ADR_CTRL = 0;
    localparam int PCC_ADR_STAT = 4;
    localparam int PCC_ADR_MODE = 8;
    localparam logic [3:0] PCC_ADR_CTRL_W = 4'h0;
    localparam logic [3:0] PCC_ADR_STAT_W = 4'h4;
    localparam logic [3:0] PCC_ADR_MODE_W = 4'h8;

    // Control register fields.
    localparam int PCC_CTL_EN_LSB = 0;
    localparam int PCC_CTL_AUTO_DIS = 4;
    localparam int PCC_CTL_HICUR = 5;
    localparam int PCC_CTL_VENDOR = 6;
    localparam int PCC_CTL_PSW_DIS = 7;
    localparam int PCC_CTL_GANGED = 8;
    localparam int PCC_CTL_POL = 9;
    localparam int PCC_CTL_CFG = 10;
    localparam logic [10:0] PCC_CTL_RESET = 11'h000;

    typedef enum logic [5:0] {
        PCC_NONE = 6'h01,
        PCC_CDP = 6'h02,
        PCC_DCP = 6'h04,
        PCC_DIV = 6'h08,
        PCC_VEND = 6'h10,
        PCC_OFF = 6'h20
    } pcc_mode_e;

    typedef enum logic [1:0] {
        PCC_SPD_SS = 2'h0,
        PCC_SPD_HS = 2'h1,
        PCC_SPD_FS = 2'h2
    } pcc_speed_e;

    typedef struct packed {
        logic [3:0] enable;
        logic auto_dis;
        logic psw_dis;
        logic ganged;
        logic pol;
    } pcc_straps_s;

    typedef struct packed {
        logic vbus_valid;
        logic configured;
        logic host_power;
    } pcc_up_s;

endpackage

//--- core/pcc_port_charging_power_control.sv
// Per-port charging mode selection and power enable control for a four-port hub.
// Assumes a classic Wishbone master, comparator inputs from the analog side and straps on pins.
`timescale 1ns/10ps
module pcc_port_charging_power_control
    import pcc_pkg::*;
#(
    parameter int OFF_CYCLES = PCC_OFF_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire pcc_straps_s straps_i,
    input wire logic upstream_connected_i,
    input wire pcc_up_s upstream_i,
    input wire logic [1:0] upstream_speed_i,
    input wire logic [3:0] dp_pullup_i,
    input wire logic [3:0] data_line_voltage_detect_i,
    output logic [3:0] port_power_enable_out_o,
    output logic [3:0] divider_charge_mode_o,
    output logic [3:0] divider_charge_high_o,
    output logic [3:0] cdp_mode_o,
    output logic [3:0] dcp_mode_o,
    output logic per_port_power_o,
    output logic power_switch_enable_o,
    output logic ds_superspeed_disable_o,
    output logic ds_highspeed_disable_o
);

    logic [10:0] ctrl_reg;
    pcc_straps_s strap_reg;
    logic strap_take_reg;
    logic [1:0] rst_seen_reg;
    pcc_straps_s strap_s1_reg;
    pcc_straps_s strap_s2_reg;
    logic [3:0] pu_s1_reg;
    logic [3:0] pu_s2_reg;
    logic [3:0] vd_s1_reg;
    logic [3:0] vd_s2_reg;
    logic [2:0] up_s1_reg;
    logic [2:0] up_s2_reg;
    logic conn_s1_reg;
    logic conn_s2_reg;
    logic [1:0] spd_s1_reg;
    logic [1:0] spd_s2_reg;
    pcc_mode_e mode_reg [PCC_PORTS];
    pcc_mode_e after_off_reg [PCC_PORTS];
    logic [PCC_CNT_W-1:0] cnt_reg [PCC_PORTS];

    logic [3:0] en_sel;
    logic auto_dis_sel;
    logic hicur_sel;
    logic vendor_sel;
    logic psw_dis_sel;
    logic ganged_sel;
    logic pol_sel;
    logic [3:0] power_on;

    // Two flip-flops on every input from outside the clock domain.
    always_ff @(posedge clk_i) begin
        strap_s1_reg <= straps_i;
        strap_s2_reg <= strap_s1_reg;
        pu_s1_reg <= dp_pullup_i;
        pu_s2_reg <= pu_s1_reg;
        vd_s1_reg <= data_line_voltage_detect_i;
        vd_s2_reg <= vd_s1_reg;
        up_s1_reg <= upstream_i;
        up_s2_reg <= up_s1_reg;
        conn_s1_reg <= upstream_connected_i;
        conn_s2_reg <= conn_s1_reg;
        spd_s1_reg <= upstream_speed_i;
        spd_s2_reg <= spd_s1_reg;
    end

    // Straps are latched once, two cycles after reset release, from the synchronised copy.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rst_seen_reg <= 2'h0;
            strap_take_reg <= 1'b0;
            strap_reg <= '0;
        end else begin
            rst_seen_reg <= {rst_seen_reg[0], 1'b1};
            if (rst_seen_reg[1] && !strap_take_reg) begin
                strap_reg <= strap_s2_reg;
                strap_take_reg <= 1'b1;
            end
        end
    end

    // Wishbone slave with one-cycle answer; ack drops the cycle after it was given.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_reg <= PCC_CTL_RESET;
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
            if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
                wb_dat_o <= 32'h0;
                case (wb_adr_i)
                    PCC_ADR_CTRL_W: begin
                        wb_dat_o <= {21'h0, ctrl_reg};
                        if (wb_we_i) begin
                            if (wb_sel_i[0]) begin
                                ctrl_reg[7:0] <= wb_dat_i[7:0];
                            end
                            if (wb_sel_i[1]) begin
                                ctrl_reg[10:8] <= wb_dat_i[10:8];
                            end
                        end
                    end
                    PCC_ADR_STAT_W: begin
                        wb_dat_o <= {16'h0, power_on, en_sel, 1'b0, strap_take_reg,
                                     spd_s2_reg, conn_s2_reg, up_s2_reg};
                    end
                    PCC_ADR_MODE_W: begin
                        wb_dat_o <= {2'h0, mode_reg[3], 2'h0, mode_reg[2], 2'h0,
                                     mode_reg[1], 2'h0, mode_reg[0]};
                    end
                    default: begin
                        wb_dat_o <= 32'h0;
                    end
                endcase
            end
        end
    end

    // Registers rule when configured over the bus, otherwise the latched straps.
    always_comb begin
        if (ctrl_reg[PCC_CTL_CFG]) begin
            en_sel = ctrl_reg[PCC_CTL_EN_LSB +: 4];
            auto_dis_sel = ctrl_reg[PCC_CTL_AUTO_DIS];
            hicur_sel = ctrl_reg[PCC_CTL_HICUR];
            vendor_sel = ctrl_reg[PCC_CTL_VENDOR];
            psw_dis_sel = ctrl_reg[PCC_CTL_PSW_DIS];
            ganged_sel = ctrl_reg[PCC_CTL_GANGED];
            pol_sel = ctrl_reg[PCC_CTL_POL];
        end else begin
            en_sel = strap_reg.enable;
            auto_dis_sel = strap_reg.auto_dis;
            hicur_sel = 1'b1;
            vendor_sel = 1'b0;
            psw_dis_sel = strap_reg.psw_dis;
            ganged_sel = strap_reg.ganged;
            pol_sel = strap_reg.pol;
        end
    end

    // Per-port charging state machines.
    for (genvar p = 0; p < PCC_PORTS; p++) begin : g_port
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                mode_reg[p] <= PCC_NONE;
                after_off_reg[p] <= PCC_NONE;
                cnt_reg[p] <= '0;
            end else if (!en_sel[p]) begin
                mode_reg[p] <= PCC_NONE;
                cnt_reg[p] <= '0;
            end else if (up_s2_reg[2]) begin
                mode_reg[p] <= (up_s2_reg[1] && up_s2_reg[0]) ? PCC_CDP : PCC_NONE;
                cnt_reg[p] <= '0;
            end else if (conn_s2_reg) begin
                mode_reg[p] <= PCC_NONE;
                cnt_reg[p] <= '0;
            end else if (auto_dis_sel) begin
                mode_reg[p] <= PCC_DCP;
                cnt_reg[p] <= '0;
            end else begin
                case (mode_reg[p])
                    PCC_DIV: begin
                        if (pu_s2_reg[p]) begin
                            after_off_reg[p] <= vendor_sel ? PCC_VEND : PCC_DCP;
                            mode_reg[p] <= PCC_OFF;
                            cnt_reg[p] <= PCC_CNT_W'(OFF_CYCLES);
                        end
                    end
                    PCC_VEND: begin
                        if (pu_s2_reg[p]) begin
                            after_off_reg[p] <= PCC_DCP;
                            mode_reg[p] <= PCC_OFF;
                            cnt_reg[p] <= PCC_CNT_W'(OFF_CYCLES);
                        end
                    end
                    PCC_DCP: begin
                        if (pu_s2_reg[p] || vd_s2_reg[p]) begin
                            after_off_reg[p] <= PCC_DIV;
                            mode_reg[p] <= PCC_OFF;
                            cnt_reg[p] <= PCC_CNT_W'(OFF_CYCLES);
                        end
                    end
                    PCC_OFF: begin
                        if (cnt_reg[p] <= PCC_CNT_W'(1)) begin
                            mode_reg[p] <= after_off_reg[p];
                            cnt_reg[p] <= '0;
                        end else begin
                            cnt_reg[p] <= cnt_reg[p] - PCC_CNT_W'(1);
                        end
                    end
                    default: begin
                        mode_reg[p] <= PCC_DIV;
                    end
                endcase
            end
        end
        assign power_on[p] = (mode_reg[p] != PCC_NONE) && (mode_reg[p] != PCC_OFF);
    end

    // Outputs, all registered.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            port_power_enable_out_o <= 4'h0;
            divider_charge_mode_o <= 4'h0;
            divider_charge_high_o <= 4'h0;
            cdp_mode_o <= 4'h0;
            dcp_mode_o <= 4'h0;
            per_port_power_o <= 1'b1;
            power_switch_enable_o <= 1'b0;
            ds_superspeed_disable_o <= 1'b0;
            ds_highspeed_disable_o <= 1'b0;
        end else begin
            for (int i = 0; i < PCC_PORTS; i++) begin
                port_power_enable_out_o[i] <= power_on[i] ^ pol_sel;
                divider_charge_mode_o[i] <= (mode_reg[i] == PCC_DIV);
                divider_charge_high_o[i] <= (mode_reg[i] == PCC_DIV) && hicur_sel;
                cdp_mode_o[i] <= (mode_reg[i] == PCC_CDP);
                dcp_mode_o[i] <= (mode_reg[i] == PCC_DCP);
            end
            per_port_power_o <= !ganged_sel || (en_sel != 4'h0);
            power_switch_enable_o <= !psw_dis_sel;
            ds_superspeed_disable_o <= (spd_s2_reg != PCC_SPD_SS);
            ds_highspeed_disable_o <= (spd_s2_reg == PCC_SPD_FS);
        end
    end

endmodule

//--- testbench/pcc_properties.sv
// Concurrent checks on the ports of the port charging and power control block.
// Assumes it is bound to the top module and sees only that module's ports.
`timescale 1ns/10ps
module pcc_properties
    import pcc_pkg::*;
#(
    parameter int OFF_CYCLES = PCC_OFF_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic upstream_connected_i,
    input wire pcc_up_s upstream_i,
    input wire logic [1:0] upstream_speed_i,
    input wire logic [3:0] divider_charge_mode_o,
    input wire logic [3:0] divider_charge_high_o,
    input wire logic [3:0] cdp_mode_o,
    input wire logic [3:0] dcp_mode_o,
    input wire logic ds_superspeed_disable_o,
    input wire logic ds_highspeed_disable_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus request not answered next cycle");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_modes_exclusive: assert property (((cdp_mode_o & dcp_mode_o) |
        ((cdp_mode_o | dcp_mode_o) & divider_charge_mode_o)) == 4'h0) else $error("two modes");
    a_high_in_divider: assert property ((divider_charge_high_o & ~divider_charge_mode_o) == 4'h0)
        else $error("high current flag outside divider mode");
    a_hs_only_speed: assert property ((upstream_speed_i == 2'h1)[*8] |->
        ds_superspeed_disable_o && !ds_highspeed_disable_o) else $error("speed limit 1");
    a_fs_only_speed: assert property ((upstream_speed_i == 2'h2)[*8] |->
        ds_superspeed_disable_o && ds_highspeed_disable_o) else $error("speed limit 2");
    a_connected_no_div: assert property (upstream_connected_i[*8] |->
        divider_charge_mode_o == 4'h0) else $error("divider while connected");
    a_vbus_no_dcp: assert property (upstream_i.vbus_valid[*8] |->
        (dcp_mode_o | divider_charge_mode_o) == 4'h0) else $error("dedicated mode with vbus");
    a_cdp_needs_vbus: assert property (!upstream_i.vbus_valid[*8] |->
        cdp_mode_o == 4'h0) else $error("cdp without vbus");
endmodule

bind pcc_port_charging_power_control pcc_properties #(.OFF_CYCLES(OFF_CYCLES)) u_props (
    .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .upstream_connected_i, .upstream_i,
    .upstream_speed_i, .divider_charge_mode_o, .divider_charge_high_o, .cdp_mode_o,
    .dcp_mode_o, .ds_superspeed_disable_o, .ds_highspeed_disable_o
);

//--- testbench/pcc_device_model.sv
// Portable devices on the four downstream ports.
// Assumes power_i is already corrected for the power enable polarity.
`timescale 1ns/10ps
module pcc_device_model (
    input wire logic [3:0] power_i,
    input wire logic [3:0] attach_i,
    input wire logic [3:0] vdat_i,
    output logic [3:0] dp_pullup_o,
    output logic [3:0] vdet_o
);
    // An unpowered device cannot hold its pull-up or drive the data line.
    assign dp_pullup_o = power_i & attach_i;
    assign vdet_o = power_i & vdat_i;
endmodule

//--- testbench/pcc_bench.sv
// Self-checking bench for the port charging and power control block.
// Assumes the design answers Wishbone one cycle after a request.
`timescale 1ns/10ps
module pcc_port_charging_power_control_bench;
    import pcc_pkg::*;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, con = 1'b0;
    logic pol_now = 1'b0, ack, ppp, pse, ssd, hsd;
    logic [3:0] adr = 4'h0, attach = 4'h0, vcmd = 4'h0, pull, vdet, pwr, div, hi, cdp, dcp;
    logic [31:0] wdat = 32'h0, rdat, q;
    logic [1:0] spd = 2'h0;
    pcc_straps_s straps = 8'hf2;
    pcc_up_s up = 3'h0;
    int bad_count = 0;
    int total_checks = 0;

    pcc_port_charging_power_control #(.OFF_CYCLES(4)) u_dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .straps_i(straps), .upstream_connected_i(con), .upstream_i(up),
        .upstream_speed_i(spd), .dp_pullup_i(pull), .data_line_voltage_detect_i(vdet),
        .port_power_enable_out_o(pwr), .divider_charge_mode_o(div), .divider_charge_high_o(hi),
        .cdp_mode_o(cdp), .dcp_mode_o(dcp), .per_port_power_o(ppp),
        .power_switch_enable_o(pse), .ds_superspeed_disable_o(ssd), .ds_highspeed_disable_o(hsd)
    );
    pcc_device_model u_dev (.power_i(pwr ^ {4{pol_now}}), .attach_i(attach), .vdat_i(vcmd),
        .dp_pullup_o(pull), .vdet_o(vdet));

    initial begin
        forever #2 clk_i = ~clk_i;
    end

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input bit ok, input string m);
        total_checks++;
        if (!ok) begin
            bad_count++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask

    // One clock with a bound; running out ends the run as a mismatch.
    task automatic tick(inout int n);
        @(posedge clk_i);
        n++;
        if (n > 100) begin
            chk(1'b0, "wait timed out");
            report_and_stop();
        end
    endtask

    task automatic settle();
        repeat (10) @(posedge clk_i);
    endtask

    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        while (ack !== 1'b1) tick(n);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic wait_pwr(input logic lv);
        int n;
        n = 0;
        while (pwr[0] !== lv) tick(n);
    endtask

    // The device on port 0 pulls up or drives the data line until power drops.
    task automatic pulse(input logic [3:0] a, input logic [3:0] v);
        attach <= a;
        vcmd <= v;
        wait_pwr(1'b0);
        attach <= 4'h0;
        vcmd <= 4'h0;
        wait_pwr(1'b1);
        settle();
    endtask

    task automatic t_rotation();
        wb(1'b1, PCC_ADR_CTRL_W, 32'h46f);
        wb(1'b0, PCC_ADR_CTRL_W, 32'h0);
        chk(q === 32'h46f, "control readback");
        settle();
        chk(div === 4'hf && hi === 4'hf && pwr === 4'hf, "start in high divider");
        pulse(4'h1, 4'h0);
        chk(div[0] === 1'b0 && dcp[0] === 1'b0 && cdp[0] === 1'b0, "vendor mode");
        pulse(4'h1, 4'h0);
        chk(dcp[0] === 1'b1, "dedicated after vendor");
        pulse(4'h0, 4'h1);
        chk(div[0] === 1'b1 && div[3:1] === 3'h7, "back to divider");
        wb(1'b0, PCC_ADR_MODE_W, 32'h0);
        chk(q === 32'h08080808, "mode readback");
    endtask

    task automatic t_case(input logic [10:0] c, input logic [3:0] u, input logic [19:0] m,
        input logic [19:0] e, input logic [1:0] g);
        wb(1'b1, PCC_ADR_CTRL_W, {21'h0, c});
        up <= u[2:0];
        con <= u[3];
        pol_now <= c[9];
        settle();
        chk(({cdp, dcp, div, hi, pwr} & m) === e && {ppp, pse} === g, "mode table");
    endtask

    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        settle();
        chk(div === 4'hf && hi === 4'hf && pwr === 4'hf, "strapped divider");
        chk(ppp === 1'b1 && pse === 1'b1, "ganged strap overridden");
        t_rotation();
        t_case(11'h42f, 4'h0, 20'hfffff, 20'h00fff, 2'h3);
        t_case(11'h405, 4'h0, 20'hfffff, 20'h00505, 2'h3);
        t_case(11'h41f, 4'h0, 20'hfffff, 20'h0f00f, 2'h3);
        t_case(11'h61f, 4'h0, 20'hfffff, 20'h0f000, 2'h3);
        t_case(11'h580, 4'h0, 20'hfffff, 20'h00000, 2'h0);
        t_case(11'h50f, 4'h7, 20'hffff0, 20'hf0000, 2'h3);
        t_case(11'h40f, 4'h8, 20'hffff0, 20'h00000, 2'h3);
        for (int s = 0; s < 3; s++) begin
            spd <= 2'(s);
            settle();
            chk(ssd === (s != 0) && hsd === (s == 2), "speed limits");
        end
        wb(1'b0, PCC_ADR_STAT_W, 32'h0);
        chk(q === 32'h00000f68, "status readback");
        wb(1'b0, 4'hc, 32'h0);
        chk(q === 32'h0, "unmapped read");
        report_and_stop();
    end
endmodule
